/* File: ildp_top.v */
// What this block does
// - Each of two channels has its own 10-bit dimming counter.
// - Internal waveform used only when that channel's internal_dim_select is set.
// - Duty is a 10-bit value split over dim_duty_high and dim_duty_low.
// - Only a dim_duty_low write moves both halves on; high alone does nothing.
// - Pending duty takes effect only at count 1022, one counter clock before period end.
// - Counter clock is the master oscillator divided by a 3-bit field ratio.
// - Master oscillator is 10.8 MHz; dimming period is 1024 counter clocks.
// - Divider code 5 selects a ratio of 24.
// - Switching enable is external_dim_input, ANDed with the internal waveform where that channel's internal_dim_select is set.
// - power_cycle_flag sets when both bias supplies are low, and at power-up.
// - Reading status_three clears power_cycle_flag.
// - In sleep, analog bias below 4 V sets analog_bias_undervolt_flag.
// - Undervoltage flag clears when software takes the device out of sleep.
// - Clearing channel_enable_bit stops that channel switching.
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "ildp_defines.vh"

module ildp_top #(
  parameter CNT_WIDTH = 10,
  parameter NUM_CH = 2
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [NUM_CH-1:0] external_dim_input,
  input wire bias_digital_low,
  input wire bias_analog_low,
  output reg [NUM_CH-1:0] switch_enable,
  output reg sleep_state,
  output reg irq
);

  reg [4:0] system_config_one;
  reg [`ILDP_DIV_WIDTH-1:0] dim_clock_divider;
  reg [1:0] dim_duty_high [0:NUM_CH-1];
  reg [7:0] dim_duty_low [0:NUM_CH-1];
  reg power_cycle_flag;
  reg analog_bias_undervolt_flag;
  reg [`ILDP_IRQ_WIDTH-1:0] irq_status;
  reg [`ILDP_IRQ_WIDTH-1:0] irq_enable;
  reg [16:0] osc_acc;
  reg osc_tick;
  reg [5:0] div_count;
  reg cnt_tick;
  reg [5:0] div_ratio;
  reg [31:0] next_prdata;
  reg next_pslverr;

  wire [NUM_CH-1:0] internal_dim_select;
  wire [NUM_CH-1:0] channel_enable_bit;
  wire sleep_request;
  wire [NUM_CH-1:0] dim_wave;
  wire [NUM_CH-1:0] period_end;
  wire [NUM_CH-1:0] duty_wr;
  wire [CNT_WIDTH*NUM_CH-1:0] active_duty;
  wire acc_phase;
  wire wr_done;
  wire rd_done;
  wire rd_status_three;
  wire pc_event;
  wire uv_event;
  wire leave_sleep;
  wire cfg_wr;
  wire [`ILDP_IRQ_WIDTH-1:0] irq_event;
  wire [`ILDP_IRQ_WIDTH-1:0] irq_clr;
  wire [16:0] acc_sum;

  assign internal_dim_select = system_config_one[`ILDP_CFG_INTSEL_LSB +: NUM_CH];
  assign channel_enable_bit = system_config_one[`ILDP_CFG_CHEN_LSB +: NUM_CH];
  assign sleep_request = system_config_one[`ILDP_CFG_SLEEP_BIT];

  // One wait state: data is registered on the same edge that raises pready
  assign acc_phase = psel & penable;
  assign wr_done = acc_phase & pready & pwrite;
  assign rd_done = acc_phase & pready & ~pwrite;
  assign rd_status_three = rd_done & (paddr == `ILDP_OFF_STATUS_THREE);
  assign cfg_wr = wr_done & (paddr == `ILDP_OFF_SYSCFG);

  assign pc_event = bias_digital_low & bias_analog_low;
  assign uv_event = sleep_request & bias_analog_low;
  assign leave_sleep = cfg_wr & sleep_request & ~pwdata[`ILDP_CFG_SLEEP_BIT];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= acc_phase & ~pready;
      if (acc_phase & ~pready) begin
        prdata <= pwrite ? 32'h0000_0000 : next_prdata;
        pslverr <= next_pslverr;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  always @* begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    case (paddr)
      `ILDP_OFF_SYSCFG: begin
        next_prdata[4:0] = system_config_one;
      end
      `ILDP_OFF_CLKDIV: begin
        next_prdata[`ILDP_DIV_WIDTH-1:0] = dim_clock_divider;
      end
      `ILDP_OFF_DUTY1_LOW: begin
        next_prdata[7:0] = dim_duty_low[0];
      end
      `ILDP_OFF_DUTY1_HIGH: begin
        next_prdata[1:0] = dim_duty_high[0];
      end
      `ILDP_OFF_DUTY2_LOW: begin
        next_prdata[7:0] = dim_duty_low[1];
      end
      `ILDP_OFF_DUTY2_HIGH: begin
        next_prdata[1:0] = dim_duty_high[1];
      end
      `ILDP_OFF_STATUS_THREE: begin
        next_prdata[`ILDP_ST_PC_BIT] = power_cycle_flag;
        next_prdata[`ILDP_ST_UV_BIT] = analog_bias_undervolt_flag;
      end
      `ILDP_OFF_IRQ_STATUS: begin
        next_prdata[`ILDP_IRQ_WIDTH-1:0] = irq_status;
      end
      `ILDP_OFF_IRQ_CLEAR: begin
        next_prdata = 32'h0000_0000;
      end
      `ILDP_OFF_IRQ_ENABLE: begin
        next_prdata[`ILDP_IRQ_WIDTH-1:0] = irq_enable;
      end
      `ILDP_OFF_DIM_STATE: begin
        next_prdata[NUM_CH-1:0] = dim_wave;
        next_prdata[8 +: NUM_CH] = switch_enable;
        next_prdata[16 +: CNT_WIDTH] = active_duty[CNT_WIDTH-1:0];
      end
      default: begin
        next_pslverr = 1'b1;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_config_one <= `ILDP_CFG_RESET;
      dim_clock_divider <= `ILDP_DIV_RESET;
      irq_enable <= {`ILDP_IRQ_WIDTH{1'b0}};
    end else if (wr_done) begin
      case (paddr)
        `ILDP_OFF_SYSCFG: begin
          system_config_one <= pwdata[4:0];
        end
        `ILDP_OFF_CLKDIV: begin
          dim_clock_divider <= pwdata[`ILDP_DIV_WIDTH-1:0];
        end
        `ILDP_OFF_IRQ_ENABLE: begin
          irq_enable <= pwdata[`ILDP_IRQ_WIDTH-1:0];
        end
        default: begin
          irq_enable <= irq_enable;
        end
      endcase
    end
  end

  // Duty halves, one pair per channel
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch = ch + 1) begin : g_ch
      wire [11:0] off_low;
      wire [11:0] off_high;
      assign off_low = (ch == 0) ? `ILDP_OFF_DUTY1_LOW : `ILDP_OFF_DUTY2_LOW;
      assign off_high = (ch == 0) ? `ILDP_OFF_DUTY1_HIGH : `ILDP_OFF_DUTY2_HIGH;
      assign duty_wr[ch] = wr_done & (paddr == off_low);

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          dim_duty_high[ch] <= 2'h0;
          dim_duty_low[ch] <= 8'h00;
        end else begin
          // High half only parks here until the low half arrives
          if (wr_done & (paddr == off_high)) begin
            dim_duty_high[ch] <= pwdata[1:0];
          end
          if (duty_wr[ch]) begin
            dim_duty_low[ch] <= pwdata[7:0];
          end
        end
      end

      ildp_chan #(
        .CNT_WIDTH(CNT_WIDTH)
      ) u_chan (
        .pclk(pclk),
        .presetn(presetn),
        .cnt_tick(cnt_tick),
        .duty_wr(duty_wr[ch]),
        .duty_in({dim_duty_high[ch], pwdata[7:0]}),
        .dim_wave(dim_wave[ch]),
        .period_end(period_end[ch]),
        .active_duty(active_duty[ch*CNT_WIDTH +: CNT_WIDTH])
      );

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          switch_enable[ch] <= 1'b0;
        end else begin
          // Held off while the power-cycle fault stands or in sleep
          switch_enable[ch] <= channel_enable_bit[ch]
            & external_dim_input[ch]
            & (~internal_dim_select[ch] | dim_wave[ch])
            & ~power_cycle_flag & ~sleep_request;
        end
      end
    end
  endgenerate

  // 10.8 MHz master tick from pclk by fractional accumulation
  assign acc_sum = osc_acc + `ILDP_OSC_KHZ;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_acc <= 17'd0;
      osc_tick <= 1'b0;
    end else begin
      if (acc_sum >= `ILDP_PCLK_KHZ) begin
        osc_acc <= acc_sum - `ILDP_PCLK_KHZ;
        osc_tick <= 1'b1;
      end else begin
        osc_acc <= acc_sum;
        osc_tick <= 1'b0;
      end
    end
  end

  always @* begin
    case (dim_clock_divider)
      3'h0: div_ratio = `ILDP_DIV_RATIO_0;
      3'h1: div_ratio = `ILDP_DIV_RATIO_1;
      3'h2: div_ratio = `ILDP_DIV_RATIO_2;
      3'h3: div_ratio = `ILDP_DIV_RATIO_3;
      3'h4: div_ratio = `ILDP_DIV_RATIO_4;
      3'h5: div_ratio = `ILDP_DIV_RATIO_5;
      3'h6: div_ratio = `ILDP_DIV_RATIO_6;
      default: div_ratio = `ILDP_DIV_RATIO_7;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_count <= 6'h00;
      cnt_tick <= 1'b0;
    end else begin
      cnt_tick <= 1'b0;
      if (osc_tick) begin
        // Reaching or passing the ratio restarts, so a smaller new code is safe
        if (div_count + 6'h01 >= div_ratio) begin
          div_count <= 6'h00;
          cnt_tick <= 1'b1;
        end else begin
          div_count <= div_count + 6'h01;
        end
      end
    end
  end

  // Status flags: a power-cycle set beats a status_three read clear in the same cycle; leaving sleep beats an undervoltage set
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_cycle_flag <= 1'b1;
      analog_bias_undervolt_flag <= 1'b0;
      sleep_state <= 1'b0;
    end else begin
      sleep_state <= sleep_request;
      if (pc_event) begin
        power_cycle_flag <= 1'b1;
      end else if (rd_status_three) begin
        power_cycle_flag <= 1'b0;
      end
      if (uv_event & ~leave_sleep) begin
        analog_bias_undervolt_flag <= 1'b1;
      end else if (leave_sleep) begin
        analog_bias_undervolt_flag <= 1'b0;
      end
    end
  end

  // Interrupt events are the rising of each flag plus period wraps
  reg pc_seen;
  reg uv_seen;

  assign irq_event[`ILDP_IRQ_PC_BIT] = power_cycle_flag & ~pc_seen;
  assign irq_event[`ILDP_IRQ_UV_BIT] = analog_bias_undervolt_flag & ~uv_seen;
  assign irq_event[`ILDP_IRQ_WRAP1_BIT] = period_end[0];
  assign irq_event[`ILDP_IRQ_WRAP2_BIT] = period_end[1];
  assign irq_clr = (wr_done & (paddr == `ILDP_OFF_IRQ_CLEAR)) ?
    pwdata[`ILDP_IRQ_WIDTH-1:0] : {`ILDP_IRQ_WIDTH{1'b0}};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_seen <= 1'b0;
      uv_seen <= 1'b0;
      irq_status <= {`ILDP_IRQ_WIDTH{1'b0}};
      irq <= 1'b0;
    end else begin
      pc_seen <= power_cycle_flag;
      uv_seen <= analog_bias_undervolt_flag;
      irq_status <= (irq_status & ~irq_clr) | irq_event;
      irq <= |(((irq_status & ~irq_clr) | irq_event) & irq_enable);
    end
  end

endmodule

/* File: ildp_defines.vh */
`ifndef ILDP_DEFINES_VH
`define ILDP_DEFINES_VH

// Register byte offsets
`define ILDP_OFF_SYSCFG 12'h000
`define ILDP_OFF_CLKDIV 12'h004
`define ILDP_OFF_DUTY1_LOW 12'h008
`define ILDP_OFF_DUTY1_HIGH 12'h00c
`define ILDP_OFF_DUTY2_LOW 12'h010
`define ILDP_OFF_DUTY2_HIGH 12'h014
`define ILDP_OFF_STATUS_THREE 12'h018
`define ILDP_OFF_IRQ_STATUS 12'h01c
`define ILDP_OFF_IRQ_CLEAR 12'h020
`define ILDP_OFF_IRQ_ENABLE 12'h024
`define ILDP_OFF_DIM_STATE 12'h028

// system_config_one fields
`define ILDP_CFG_INTSEL_LSB 0
`define ILDP_CFG_CHEN_LSB 2
`define ILDP_CFG_SLEEP_BIT 4
`define ILDP_CFG_RESET 5'h00

// dim_clock_divider
`define ILDP_DIV_WIDTH 3
`define ILDP_DIV_RESET 3'h5
`define ILDP_DIV_RATIO_0 6'h01
`define ILDP_DIV_RATIO_1 6'h02
`define ILDP_DIV_RATIO_2 6'h04
`define ILDP_DIV_RATIO_3 6'h08
`define ILDP_DIV_RATIO_4 6'h10
`define ILDP_DIV_RATIO_5 6'h18
`define ILDP_DIV_RATIO_6 6'h20
`define ILDP_DIV_RATIO_7 6'h30

// status_three fields
`define ILDP_ST_PC_BIT 0
`define ILDP_ST_UV_BIT 1

// Interrupt event bits
`define ILDP_IRQ_PC_BIT 0
`define ILDP_IRQ_UV_BIT 1
`define ILDP_IRQ_WRAP1_BIT 2
`define ILDP_IRQ_WRAP2_BIT 3
`define ILDP_IRQ_WIDTH 4

// Dimming counter
`define ILDP_CNT_WIDTH 10
`define ILDP_CNT_LOAD 10'h3fe
`define ILDP_CNT_LAST 10'h3ff

// Master oscillator derived from pclk
`define ILDP_PCLK_KHZ 17'd100000
`define ILDP_OSC_KHZ 17'd10800

`endif

/* File: ildp_chan.v */
`timescale 1ns/1ns
`include "ildp_defines.vh"

module ildp_chan #(
  parameter CNT_WIDTH = 10
) (
  input wire pclk,
  input wire presetn,
  input wire cnt_tick,
  input wire duty_wr,
  input wire [CNT_WIDTH-1:0] duty_in,
  output reg dim_wave,
  output reg period_end,
  output wire [CNT_WIDTH-1:0] active_duty
);

  reg [CNT_WIDTH-1:0] count;
  reg [CNT_WIDTH-1:0] pending;
  reg [CNT_WIDTH-1:0] active;

  assign active_duty = active;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= {CNT_WIDTH{1'b0}};
      pending <= {CNT_WIDTH{1'b0}};
      active <= {CNT_WIDTH{1'b0}};
      dim_wave <= 1'b0;
      period_end <= 1'b0;
    end else begin
      period_end <= 1'b0;
      if (duty_wr) begin
        pending <= duty_in;
      end
      if (cnt_tick) begin
        count <= count + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
        // Late swap keeps the running period intact
        if (count == `ILDP_CNT_LOAD) begin
          active <= duty_wr ? duty_in : pending;
        end
        if (count == `ILDP_CNT_LAST) begin
          period_end <= 1'b1;
        end
      end
      dim_wave <= (count < active);
    end
  end

endmodule

/* File: ildp_monitor.sv */
`timescale 1ns/1ns
module ildp_monitor #(
  parameter CNT_WIDTH = 10,
  parameter NUM_CH = 2
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [NUM_CH-1:0] external_dim_input,
  input wire bias_digital_low,
  input wire bias_analog_low,
  input wire [NUM_CH-1:0] switch_enable,
  input wire sleep_state,
  input wire irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access_start;
    psel && penable && !$past(penable);
  endsequence
  sequence s_one_wait;
    !pready ##1 pready;
  endsequence
  a_ready_one_wait: assert property (s_access_start |-> s_one_wait)
    else $error("pready not after exactly one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_needs_sel: assert property (pready |-> psel && penable)
    else $error("pready outside an access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_rdata_hold: assert property (!psel ##1 !psel |-> $stable(prdata))
    else $error("prdata changed while idle");
  a_gate_ext_one: assert property (!external_dim_input[0] |=> !switch_enable[0])
    else $error("channel one switching with external input low");
  a_gate_ext_two: assert property (!external_dim_input[1] |=> !switch_enable[1])
    else $error("channel two switching with external input low");
  a_sleep_blocks: assert property (sleep_state |-> switch_enable == 2'h0)
    else $error("switching while asleep");
endmodule

bind ildp_top ildp_monitor #(.CNT_WIDTH(CNT_WIDTH), .NUM_CH(NUM_CH)) i_ildp_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .external_dim_input(external_dim_input), .bias_digital_low(bias_digital_low),
  .bias_analog_low(bias_analog_low), .switch_enable(switch_enable),
  .sleep_state(sleep_state), .irq(irq));

/* File: ildp_host.sv */
`timescale 1ns/1ns
`include "ildp_defines.vh"
module ildp_host (
  input wire pclk,
  input wire pready,
  input wire pslverr,
  input wire [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  logic [31:0] rdat;
  logic rerr;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // Waits for pready however long it takes; only the bench watchdog ends a hang
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
        @(posedge pclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released data must not look like the last value
      pwdata <= ~d;
    end
  endtask
  // High half first, low half at once after it
  task set_duty(input logic ch, input logic [9:0] d);
    begin
      xfer(1'b1, ch ? `ILDP_OFF_DUTY2_HIGH : `ILDP_OFF_DUTY1_HIGH, {30'h0, d[9:8]});
      xfer(1'b1, ch ? `ILDP_OFF_DUTY2_LOW : `ILDP_OFF_DUTY1_LOW, {24'h0, d[7:0]});
    end
  endtask
endmodule

/* File: tb.sv */
`timescale 1ns/1ns
`include "ildp_defines.vh"
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [1:0] external_dim_input = 2'h0;
  logic bias_digital_low = 1'b0;
  logic bias_analog_low = 1'b0;
  wire psel, penable, pwrite, pready, pslverr, sleep_state, irq;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  wire [1:0] switch_enable;
  int err_total = 0;
  int checks = 0;
  always #5 pclk = ~pclk;
  ildp_host i_ildp_host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  ildp_top i_ildp_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_dim_input(external_dim_input),
    .bias_digital_low(bias_digital_low), .bias_analog_low(bias_analog_low),
    .switch_enable(switch_enable), .sleep_state(sleep_state), .irq(irq));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      checks++;
      if (got !== exp) begin
        err_total++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    i_ildp_host.xfer(1'b1, a, d);
  endtask
  task rd(input logic [11:0] a);
    i_ildp_host.xfer(1'b0, a, 32'h0);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] exp);
    begin
      rd(a);
      chk(i_ildp_host.rdat, exp);
    end
  endtask
  // Applied duty shows only after the next count of 1022
  task wait_duty(input logic [9:0] d);
    int n;
    begin
      n = 0;
      do begin
        rd(`ILDP_OFF_DIM_STATE);
        n++;
      end while (i_ildp_host.rdat[25:16] !== d && n < 3000);
    end
  endtask
  // One period at divider code 0 (ratio 1) is about 1024 * 1000 / 108 pclk cycles
  function automatic int exp_high(input logic [9:0] d);
    return int'(d) * 1000 / 108;
  endfunction
  task settle;
    repeat (3) @(posedge pclk);
  endtask
  task report_and_stop;
    begin
      $display("checks=%0d err_total=%0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    #1_000_000;
    err_total++;
    report_and_stop();
  end
  initial begin : main
    int r;
    int n;
    int e;
    logic [9:0] duty [3];
    r = $urandom(93);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    chk({30'h0, switch_enable}, 32'h0);
    rdc(`ILDP_OFF_CLKDIV, 32'h5);
    rdc(`ILDP_OFF_IRQ_STATUS, 32'h1);
    rdc(`ILDP_OFF_STATUS_THREE, 32'h1);
    rdc(`ILDP_OFF_STATUS_THREE, 32'h0);
    rdc(12'h100, 32'h0);
    chk({31'h0, i_ildp_host.rerr}, 32'h1);
    wr(`ILDP_OFF_IRQ_CLEAR, 32'h1);
    rdc(`ILDP_OFF_IRQ_STATUS, 32'h0);
    $display("reset test done");
    wr(`ILDP_OFF_CLKDIV, 32'h0);
    rdc(`ILDP_OFF_CLKDIV, 32'h0);
    external_dim_input <= 2'h3;
    wr(`ILDP_OFF_SYSCFG, 32'h0d);
    settle();
    chk({31'h0, switch_enable[1]}, 32'h1);
    external_dim_input[1] <= 1'b0;
    settle();
    chk({31'h0, switch_enable[1]}, 32'h0);
    wr(`ILDP_OFF_IRQ_ENABLE, 32'h4);
    r = $urandom;
    duty[0] = r[9:0];
    duty[1] = 10'h000;
    duty[2] = 10'h3ff;
    for (int i = 0; i < 3; i++) begin
      i_ildp_host.set_duty(1'b0, duty[i]);
      wait_duty(duty[i]);
      chk({22'h0, i_ildp_host.rdat[25:16]}, {22'h0, duty[i]});
      n = 0;
      repeat (9482) begin
        @(posedge pclk);
        if (switch_enable[0] === 1'b1) n++;
      end
      e = exp_high(duty[i]);
      chk({31'h0, n >= e - 60 && n <= e + 60}, 32'h1);
    end
    $display("duty test done");
    chk({31'h0, irq}, 32'h1);
    wr(`ILDP_OFF_IRQ_ENABLE, 32'h0);
    settle();
    chk({31'h0, irq}, 32'h0);
    rd(`ILDP_OFF_IRQ_STATUS);
    chk({31'h0, i_ildp_host.rdat[2]}, 32'h1);
    wr(`ILDP_OFF_IRQ_CLEAR, 32'hc);
    rd(`ILDP_OFF_IRQ_STATUS);
    chk({31'h0, i_ildp_host.rdat[2]}, 32'h0);
    $display("irq test done");
    wr(`ILDP_OFF_DUTY1_HIGH, 32'h0);
    i_ildp_host.set_duty(1'b1, 10'h2aa);
    repeat (9600) @(posedge pclk);
    rd(`ILDP_OFF_DIM_STATE);
    chk({22'h0, i_ildp_host.rdat[25:16]}, 32'h3ff);
    external_dim_input[0] <= 1'b0;
    settle();
    chk({31'h0, switch_enable[0]}, 32'h0);
    external_dim_input[0] <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (switch_enable[0] !== 1'b1 && n < 40);
    chk({31'h0, switch_enable[0]}, 32'h1);
    wr(`ILDP_OFF_SYSCFG, 32'h01);
    settle();
    chk({31'h0, switch_enable[0]}, 32'h0);
    wr(`ILDP_OFF_SYSCFG, 32'h1d);
    bias_analog_low <= 1'b1;
    settle();
    chk({31'h0, sleep_state}, 32'h1);
    chk({30'h0, switch_enable}, 32'h0);
    rdc(`ILDP_OFF_STATUS_THREE, 32'h2);
    wr(`ILDP_OFF_SYSCFG, 32'h0d);
    rdc(`ILDP_OFF_STATUS_THREE, 32'h0);
    $display("sleep test done");
    bias_digital_low <= 1'b1;
    settle();
    bias_digital_low <= 1'b0;
    bias_analog_low <= 1'b0;
    settle();
    chk({30'h0, switch_enable}, 32'h0);
    rdc(`ILDP_OFF_STATUS_THREE, 32'h1);
    rdc(`ILDP_OFF_STATUS_THREE, 32'h0);
    $display("power cycle test done");
    report_and_stop();
  end
endmodule
